//--- hw/twh_div.sv
// Quarter-bit tick divider for the bus clock generator.
`timescale 1ns/1ps
module twh_div
	import twh_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [15:0] period,
	output logic tick
);
	twh_div_t q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!enable) begin
			d.cnt = 16'h0000;
		end else if (q.cnt >= period) begin
			d.cnt = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule : twh_div

//--- hw/twh_map.svh
// Register offsets, field positions, reset values and status codes.
`ifndef TWH_MAP_SVH
`define TWH_MAP_SVH
`define TWH_IDX_CTRL 3'h0
`define TWH_IDX_DATA 3'h1
`define TWH_IDX_STAT 3'h2
`define TWH_IDX_RATE 3'h3
`define TWH_IDX_OWN 3'h4
`define TWH_IDX_IRQ_ST 3'h5
`define TWH_IDX_IRQ_MSK 3'h6
`define TWH_CTL_FLAG 7
`define TWH_CTL_ACK 6
`define TWH_CTL_STA 5
`define TWH_CTL_STO 4
`define TWH_CTL_WCOL 3
`define TWH_CTL_EN 2
`define TWH_IRQ_DONE 0
`define TWH_IRQ_WCOL 1
`define TWH_RST_RATE 8'h10
`define TWH_RST_OWN 7'h00
`define TWH_SC_START 8'h08
`define TWH_SC_RSTART 8'h10
`define TWH_SC_MT_SLA_ACK 8'h18
`define TWH_SC_MT_SLA_NACK 8'h20
`define TWH_SC_MT_DAT_ACK 8'h28
`define TWH_SC_MT_DAT_NACK 8'h30
`define TWH_SC_ARB_LOST 8'h38
`define TWH_SC_MR_SLA_ACK 8'h40
`define TWH_SC_MR_SLA_NACK 8'h48
`define TWH_SC_MR_DAT_ACK 8'h50
`define TWH_SC_MR_DAT_NACK 8'h58
`define TWH_SC_SR_SLA_ACK 8'h60
`define TWH_SC_SR_DAT_ACK 8'h80
`define TWH_SC_SR_DAT_NACK 8'h88
`define TWH_SC_SR_STOP 8'ha0
`define TWH_SC_ST_SLA_ACK 8'ha8
`define TWH_SC_ST_DAT_ACK 8'hb8
`define TWH_SC_ST_DAT_NACK 8'hc0
`define TWH_SC_NONE 8'hf8
`endif

//--- hw/twh_pin_if.sv
// Filtered view of one bus line passed from its synchroniser to the core.
`timescale 1ns/1ps
interface twh_pin_if;
	logic raw;
	logic level;
	logic rise;
	logic fall;
	modport filt (input raw, output level, output rise, output fall);
	modport use_side (input level, input rise, input fall);
endinterface : twh_pin_if

//--- hw/twh_pkg.sv
// Types shared by the two-wire byte interface modules.
package twh_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_MSTART, ST_MXFER, ST_MSTOP, ST_SXFER, ST_HOLD
	} twh_fsm_t;
	typedef enum logic [2:0] {
		NO_MODE, MASTER_TRANSMIT_MODE, MASTER_RECEIVE_MODE,
		SLAVE_TRANSMIT_MODE, SLAVE_RECEIVE_MODE
	} twh_mode_t;
	typedef struct packed {
		twh_fsm_t st;
		twh_mode_t mode;
		logic ctl_en;
		logic ctl_ack;
		logic ctl_sta;
		logic ctl_sto;
		logic flag;
		logic wcol;
		logic [7:0] data;
		logic [4:0] code;
		logic [1:0] presc;
		logic [7:0] rate;
		logic [6:0] own;
		logic [1:0] irq_st;
		logic [1:0] irq_msk;
		logic [3:0] bitcnt;
		logic [1:0] phase;
		logic addr_ph;
		logic rep;
		logic acked;
		logic last;
		logic hold_scl;
		logic busy;
		logic scl_oe;
		logic sda_oe;
		logic wr_pend;
		logic [2:0] wr_idx;
		logic [31:0] hrdata;
		logic hrdy;
		logic zero;
		logic irq;
	} twh_state_t;
	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic level;
		logic rise;
		logic fall;
	} twh_sync_t;
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} twh_div_t;
endpackage : twh_pkg

//--- hw/twh_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
module twh_sync
	import twh_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	twh_pin_if.filt pin
);
	twh_sync_t q, d;

	always_comb begin
		d = q;
		d.f1 = pin.raw;
		d.f2 = q.f1;
		d.f3 = q.f2;
		d.rise = 1'b0;
		d.fall = 1'b0;
		if (q.f2 == q.f3 && q.f3 != q.level) begin
			d.level = q.f3;
			d.rise = q.f3;
			d.fall = ~q.f3;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.f1 <= 1'b1;
			q.f2 <= 1'b1;
			q.f3 <= 1'b1;
			q.level <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign pin.level = q.level;
	assign pin.rise = q.rise;
	assign pin.fall = q.fall;
endmodule : twh_sync

//--- hw/twh_top.sv
// Two-wire byte interface core with AHB-Lite register access.
// Notes on behaviour
// - The completion flag is set whenever a bus step ends and software must answer.
// - While the flag is set the core pulls the clock line low, except after arbitration loss (38) or a stop or repeated start seen as slave (a0).
// - A control write with a one at the flag position clears it; a zero leaves it.
// - Clearing the flag launches the operation chosen by the new control bits.
// - The core works as master transmitter, master receiver, slave transmitter and slave receiver.
// - The direction bit after the address is high for read and low for write.
// - Acknowledge is the data line low in the ninth bit; not-acknowledge is left high.
// - After sending a start the core sets the flag with status code 08, or 10 for a repeated start.
// - A data write while the flag is low is dropped and sets the collision bit.
`timescale 1ns/1ps
`include "twh_map.svh"
module twh_top
	import twh_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	twh_state_t q, n;
	logic tick;
	logic [15:0] period;
	twh_pin_if scl_if ();
	twh_pin_if sda_if ();

	assign scl_if.raw = scl_i;
	assign sda_if.raw = sda_i;
	assign period = (16'h0001 + {8'h00, q.rate}) << {q.presc, 1'b0};

	twh_sync u_scl_sync (.clock(clock), .reset_n(reset_n), .pin(scl_if));
	twh_sync u_sda_sync (.clock(clock), .reset_n(reset_n), .pin(sda_if));
	twh_div u_div (
		.clock(clock),
		.reset_n(reset_n),
		.enable(q.ctl_en),
		.period(period),
		.tick(tick)
	);

	function automatic logic [4:0] sc(input logic [7:0] c);
		return c[7:3];
	endfunction : sc

	function automatic logic [31:0] rd_mux(input logic [2:0] idx,
		input twh_state_t s);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`TWH_IDX_CTRL: v = {s.flag, s.ctl_ack, s.ctl_sta, s.ctl_sto,
				s.wcol, s.ctl_en, 2'b00};
			`TWH_IDX_DATA: v = s.data;
			`TWH_IDX_STAT: v = {(s.flag ? s.code : sc(`TWH_SC_NONE)),
				1'b0, s.presc};
			`TWH_IDX_RATE: v = s.rate;
			`TWH_IDX_OWN: v = {1'b0, s.own};
			`TWH_IDX_IRQ_ST: v = {6'h00, s.irq_st};
			`TWH_IDX_IRQ_MSK: v = {6'h00, s.irq_msk};
			default: v = 8'h00;
		endcase
		return {24'h000000, v};
	endfunction : rd_mux

	always_comb begin
		logic [7:0] wd;
		logic clr;
		logic go;
		logic adv;
		logic tx;
		logic sta_det;
		logic sto_det;
		logic ev_done;
		logic ev_wcol;
		wd = hwdata[7:0];
		clr = 1'b0;
		go = 1'b0;
		adv = 1'b0;
		tx = 1'b0;
		ev_done = 1'b0;
		ev_wcol = 1'b0;
		n = q;
		sta_det = sda_if.fall && scl_if.level;
		sto_det = sda_if.rise && scl_if.level;
		if (sta_det) begin
			n.busy = 1'b1;
		end else if (sto_det) begin
			n.busy = 1'b0;
		end

		// Data phase of a write accepted in the previous cycle.
		if (q.wr_pend) begin
			unique case (q.wr_idx)
				`TWH_IDX_CTRL: begin
					n.ctl_en = wd[`TWH_CTL_EN];
					n.ctl_ack = wd[`TWH_CTL_ACK];
					n.ctl_sta = wd[`TWH_CTL_STA];
					n.ctl_sto = wd[`TWH_CTL_STO];
					clr = wd[`TWH_CTL_FLAG];
				end
				`TWH_IDX_DATA: begin
					if (q.flag) begin
						n.data = wd;
						n.wcol = 1'b0;
					end else begin
						ev_wcol = 1'b1;
					end
				end
				`TWH_IDX_STAT: n.presc = wd[1:0];
				`TWH_IDX_RATE: n.rate = wd;
				`TWH_IDX_OWN: n.own = wd[6:0];
				`TWH_IDX_IRQ_ST: n.irq_st = q.irq_st & ~wd[1:0];
				`TWH_IDX_IRQ_MSK: n.irq_msk = wd[1:0];
				default: n.irq_msk = q.irq_msk;
			endcase
		end
		if (clr) begin
			n.flag = 1'b0;
		end
		go = clr && q.flag;

		adv = tick && (q.phase != 2'd2 || scl_if.level);
		if (!n.ctl_en) begin
			n.st = ST_IDLE;
			n.mode = NO_MODE;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.ctl_sto = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
					n.scl_oe = 1'b0;
					n.sda_oe = 1'b0;
					if (n.ctl_sta && !n.flag && !q.busy) begin
						n.st = ST_MSTART;
						n.phase = 2'd0;
						n.rep = 1'b0;
					end else if (sta_det) begin
						n.st = ST_SXFER;
						n.bitcnt = 4'd0;
						n.addr_ph = 1'b1;
					end
				end
				ST_MSTART: if (adv) begin
					n.phase = q.phase + 2'd1;
					unique case (q.phase)
						2'd0: n.sda_oe = 1'b0;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b1;
						2'd3: begin
							n.scl_oe = 1'b1;
							n.flag = 1'b1;
							n.code = q.rep ? sc(`TWH_SC_RSTART) :
								sc(`TWH_SC_START);
							n.addr_ph = 1'b1;
							n.mode = MASTER_TRANSMIT_MODE;
							n.hold_scl = 1'b1;
							n.st = ST_HOLD;
							ev_done = 1'b1;
						end
					endcase
				end
				ST_MXFER: begin
					tx = q.addr_ph || q.mode == MASTER_TRANSMIT_MODE;
					if (adv) begin
						n.phase = q.phase + 2'd1;
						unique case (q.phase)
							2'd0: n.sda_oe = (q.bitcnt == 4'd8) ?
								(!tx && q.ctl_ack) :
								(tx && !q.data[7]);
							2'd1: n.scl_oe = 1'b0;
							2'd2: begin
								if (q.bitcnt != 4'd8) begin
									if (tx && q.data[7] && !sda_if.level) begin
										n.sda_oe = 1'b0;
										n.flag = 1'b1;
										n.code = sc(`TWH_SC_ARB_LOST);
										n.mode = NO_MODE;
										n.hold_scl = 1'b0;
										n.st = ST_HOLD;
										ev_done = 1'b1;
									end
									n.data = {q.data[6:0], sda_if.level};
								end else begin
									n.acked = !sda_if.level;
								end
							end
							2'd3: begin
								n.scl_oe = 1'b1;
								if (q.bitcnt != 4'd8) begin
									n.bitcnt = q.bitcnt + 4'd1;
								end else begin
									n.flag = 1'b1;
									ev_done = 1'b1;
									n.hold_scl = 1'b1;
									n.st = ST_HOLD;
									n.addr_ph = 1'b0;
									if (q.addr_ph && q.data[0]) begin
										n.mode = MASTER_RECEIVE_MODE;
										n.code = q.acked ? sc(`TWH_SC_MR_SLA_ACK) :
											sc(`TWH_SC_MR_SLA_NACK);
									end else if (q.addr_ph) begin
										n.mode = MASTER_TRANSMIT_MODE;
										n.code = q.acked ? sc(`TWH_SC_MT_SLA_ACK) :
											sc(`TWH_SC_MT_SLA_NACK);
									end else if (tx) begin
										n.code = q.acked ? sc(`TWH_SC_MT_DAT_ACK) :
											sc(`TWH_SC_MT_DAT_NACK);
									end else begin
										n.code = q.acked ? sc(`TWH_SC_MR_DAT_ACK) :
											sc(`TWH_SC_MR_DAT_NACK);
									end
								end
							end
						endcase
					end
				end
				ST_MSTOP: if (adv) begin
					n.phase = q.phase + 2'd1;
					unique case (q.phase)
						2'd0: n.sda_oe = 1'b1;
						2'd1: n.scl_oe = 1'b0;
						2'd2: n.sda_oe = 1'b0;
						2'd3: begin
							n.ctl_sto = 1'b0;
							n.mode = NO_MODE;
							n.st = ST_IDLE;
						end
					endcase
				end
				ST_SXFER: begin
					tx = q.mode == SLAVE_TRANSMIT_MODE && !q.addr_ph;
					if (sto_det || sta_det) begin
						n.sda_oe = 1'b0;
						n.bitcnt = 4'd0;
						if (q.addr_ph) begin
							n.st = sto_det ? ST_IDLE : ST_SXFER;
						end else begin
							n.flag = 1'b1;
							n.code = sc(`TWH_SC_SR_STOP);
							n.mode = NO_MODE;
							n.hold_scl = 1'b0;
							n.last = 1'b1;
							n.st = ST_HOLD;
							ev_done = 1'b1;
						end
					end else if (scl_if.rise) begin
						if (q.bitcnt != 4'd8) begin
							n.data = {q.data[6:0], sda_if.level};
						end else begin
							n.acked = !sda_if.level;
						end
					end else if (scl_if.fall) begin
						if (q.bitcnt < 4'd7) begin
							n.bitcnt = q.bitcnt + 4'd1;
							n.sda_oe = tx && !q.data[7];
						end else if (q.bitcnt == 4'd7) begin
							n.bitcnt = 4'd8;
							if (q.addr_ph) begin
								if (q.data[7:1] == q.own && q.ctl_ack) begin
									n.sda_oe = 1'b1;
								end else begin
									n.sda_oe = 1'b0;
									n.st = ST_IDLE;
								end
							end else begin
								n.sda_oe = !tx && q.ctl_ack;
							end
						end else begin
							n.sda_oe = 1'b0;
							n.scl_oe = 1'b1;
							n.hold_scl = 1'b1;
							n.flag = 1'b1;
							ev_done = 1'b1;
							n.st = ST_HOLD;
							n.addr_ph = 1'b0;
							n.last = 1'b0;
							if (q.addr_ph && q.data[0]) begin
								n.mode = SLAVE_TRANSMIT_MODE;
								n.code = sc(`TWH_SC_ST_SLA_ACK);
							end else if (q.addr_ph) begin
								n.mode = SLAVE_RECEIVE_MODE;
								n.code = sc(`TWH_SC_SR_SLA_ACK);
							end else if (tx) begin
								n.code = q.acked ? sc(`TWH_SC_ST_DAT_ACK) :
									sc(`TWH_SC_ST_DAT_NACK);
								n.last = !q.acked;
							end else begin
								n.code = q.acked ? sc(`TWH_SC_SR_DAT_ACK) :
									sc(`TWH_SC_SR_DAT_NACK);
								n.last = !q.acked;
							end
						end
					end
				end
				ST_HOLD: begin
					n.scl_oe = q.hold_scl;
					if (go) begin
						n.phase = 2'd0;
						n.bitcnt = 4'd0;
						n.hold_scl = 1'b0;
						if (q.mode == MASTER_TRANSMIT_MODE ||
							q.mode == MASTER_RECEIVE_MODE) begin
							if (n.ctl_sto) begin
								n.st = ST_MSTOP;
							end else if (n.ctl_sta) begin
								n.st = ST_MSTART;
								n.rep = 1'b1;
							end else begin
								n.st = ST_MXFER;
							end
						end else if (q.mode != NO_MODE && !q.last &&
							!n.ctl_sto) begin
							n.st = ST_SXFER;
							n.scl_oe = 1'b0;
							n.sda_oe = q.mode == SLAVE_TRANSMIT_MODE &&
								!q.data[7];
						end else begin
							n.st = ST_IDLE;
							n.ctl_sto = 1'b0;
							n.mode = NO_MODE;
							n.scl_oe = 1'b0;
							n.sda_oe = 1'b0;
						end
					end
				end
			endcase
		end

		// Event bits: a hardware set wins over a software clear.
		if (ev_wcol) begin
			n.wcol = 1'b1;
			n.irq_st[`TWH_IRQ_WCOL] = 1'b1;
		end
		if (ev_done) begin
			n.irq_st[`TWH_IRQ_DONE] = 1'b1;
		end
		n.irq = |(n.irq_st & n.irq_msk);

		// Address phase; reads use the updated values.
		n.wr_pend = hsel && hready && htrans[1] && hwrite &&
			hsize == 3'b010;
		n.wr_idx = haddr[4:2];
		n.hrdata = (hsel && hready && htrans[1] && !hwrite) ?
			rd_mux(haddr[4:2], n) : 32'h00000000;
		n.hrdy = 1'b1;
		n.zero = 1'b0;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.rate <= `TWH_RST_RATE;
			q.own <= `TWH_RST_OWN;
			q.hrdy <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hrdy;
	assign hresp = q.zero;
	assign irq = q.irq;
	assign scl_o = q.zero;
	assign sda_o = q.zero;
	assign scl_oe = q.scl_oe;
	assign sda_oe = q.sda_oe;
endmodule : twh_top

//--- sim/twh_slave_model.sv
// Behavioural target device answering on the two-wire bus.
`timescale 1ns/1ps
module twh_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack,
	input wire logic slow,
	input wire logic [7:0] tx_byte,
	output logic sda_pull,
	output logic scl_pull,
	output logic [7:0] rx_byte
);
	logic [7:0] b;
	logic rd;
	logic go;
	initial begin
		sda_pull = 1'b0;
		scl_pull = 1'b0;
		rx_byte = 8'h00;
	end
	task automatic get_byte();
		for (int i = 7; i >= 0; i--) begin
			@(negedge scl);
			sda_pull = rd && !tx_byte[i];
			@(posedge scl);
			b = {b[6:0], sda};
		end
		rx_byte = b;
	endtask : get_byte
	task automatic ack_bit(input logic a);
		@(negedge scl);
		sda_pull = a;
		if (slow) begin
			scl_pull = 1'b1;
			#1000 scl_pull = 1'b0;
		end
		@(posedge scl);
	endtask : ack_bit
	always begin
		@(negedge sda iff scl === 1'b1);
		fork : frame
			@(posedge sda iff scl === 1'b1);
			begin
				rd = 1'b0;
				get_byte();
				go = b[7:1] == ADDR;
				rd = b[0];
				ack_bit(go && !nack);
				while (go) begin
					get_byte();
					if (rd) begin
						@(negedge scl);
						sda_pull = 1'b0;
						@(posedge scl);
						go = !sda;
					end else
						ack_bit(!nack);
				end
				wait (1'b0);
			end
		join_any
		disable frame;
		sda_pull = 1'b0;
		scl_pull = 1'b0;
	end
endmodule : twh_slave_model

//--- sim/twh_top_bench.sv
// Self-checking bench for the two-wire byte interface.
`timescale 1ns/1ps
`include "twh_map.svh"
module twh_top_bench
	import twh_pkg::*;
;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rdv, r;
	logic hreadyout, hresp, irq, scl_o, scl_oe, sda_o, sda_oe;
	logic nack = 1'b0;
	logic slow = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rx_byte;
	logic sda_pull, scl_pull;
	wire scl = !(scl_oe || scl_pull);
	wire sda = !(sda_oe || sda_pull);
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] seed = 32'd16941;
	always #12.5 clock = !clock;
	twh_top twh_top_inst (.clock(clock), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .scl_i(scl),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe));
	twh_slave_model twh_slave_model_inst (.scl(scl), .sda(sda), .nack(nack),
		.slow(slow), .tx_byte(tx_byte), .sda_pull(sda_pull),
		.scl_pull(scl_pull), .rx_byte(rx_byte));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [7:0] exp_code(input logic rd, input logic d,
		input logic n);
		case ({rd, d})
			2'b00: return n ? `TWH_SC_MT_SLA_NACK : `TWH_SC_MT_SLA_ACK;
			2'b01: return n ? `TWH_SC_MT_DAT_NACK : `TWH_SC_MT_DAT_ACK;
			2'b10: return n ? `TWH_SC_MR_SLA_NACK : `TWH_SC_MR_SLA_ACK;
			default: return n ? `TWH_SC_MR_DAT_NACK : `TWH_SC_MR_DAT_ACK;
		endcase
	endfunction : exp_code
	task automatic summarize();
		if (num_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [2:0] idx,
		input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {27'h0, idx, 2'h0};
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clock); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask : bus
	task automatic step(input logic [7:0] ctl, input logic [7:0] code);
		bus(1'b1, 3'h5, 8'h03);
		bus(1'b1, 3'h0, ctl);
		do bus(1'b0, 3'h0, 8'h00); while (rdv[7] !== 1'b1);
		bus(1'b0, 3'h2, 8'h00);
		chk("status code", code, rdv[7:0] & 8'hf8);
		chk("clock held", 8'h01, {7'h0, scl_oe});
		chk("irq on flag", 8'h01, {7'h0, irq});
	endtask : step
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		bus(1'b0, 3'h2, 8'h00);
		chk("status idle", 8'hf8, rdv[7:0]);
		bus(1'b0, 3'h7, 8'h00);
		chk("unmapped", 8'h00, rdv[7:0]);
		r = xs();
		bus(1'b1, 3'h2, {6'h0, r[1:0]});
		bus(1'b0, 3'h2, 8'h00);
		chk("prescaler", {5'h1f, 1'b0, r[1:0]}, rdv[7:0]);
		bus(1'b1, 3'h2, 8'h00);
		bus(1'b1, 3'h3, 8'h03);
		bus(1'b1, 3'h6, 8'h00);
		bus(1'b1, 3'h0, 8'h04);
		bus(1'b1, 3'h1, 8'h5a);
		bus(1'b0, 3'h0, 8'h00);
		chk("collision", 8'h08, rdv[7:0] & 8'h08);
		chk("irq masked", 8'h00, {7'h0, irq});
		bus(1'b1, 3'h6, 8'h03);
		repeat (2) @(posedge clock);
		chk("irq raised", 8'h01, {7'h0, irq});
		bus(1'b1, 3'h5, 8'h03);
		repeat (2) @(posedge clock);
		chk("irq cleared", 8'h00, {7'h0, irq});
		for (int k = 0; k < 3; k++) begin
			r = xs();
			slow <= r[0];
			tx_byte <= r[15:8];
			nack <= k == 1;
			step(8'ha4, `TWH_SC_START);
			bus(1'b1, 3'h0, 8'h04);
			bus(1'b0, 3'h0, 8'h00);
			chk("flag kept", 8'h80, rdv[7:0] & 8'h80);
			bus(1'b1, 3'h1, {7'h2a, k == 2});
			step(8'h84, exp_code(k == 2, 1'b0, k == 1));
			chk("address on wire", {7'h2a, k == 2}, rx_byte);
			if (k == 0) begin
				bus(1'b1, 3'h1, r[23:16]);
				step(8'h84, exp_code(1'b0, 1'b1, 1'b0));
				chk("byte on wire", r[23:16], rx_byte);
			end
			if (k == 2) begin
				step(8'hc4, exp_code(1'b1, 1'b1, 1'b0));
				bus(1'b0, 3'h1, 8'h00);
				chk("byte read", r[15:8], rdv[7:0]);
				step(8'h84, exp_code(1'b1, 1'b1, 1'b1));
			end
			bus(1'b1, 3'h0, 8'h94);
			do bus(1'b0, 3'h0, 8'h00); while (rdv[4] !== 1'b0);
			repeat (2) @(posedge clock);
			chk("lines free", 8'h00, {6'h0, scl_oe, sda_oe});
		end
		summarize();
	end
endmodule : twh_top_bench

//--- sim/twh_top_chk.sv
// Port checker for the two-wire byte interface core.
`timescale 1ns/1ps
module twh_top_chk
	import twh_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	logic rd_q, st_q, wr_q, en_q, msk_q;
	logic [2:0] idx_q;
	wire take = hsel && hready && htrans[1];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= 1'b0;
			st_q <= 1'b0;
			wr_q <= 1'b0;
			en_q <= 1'b0;
			msk_q <= 1'b0;
			idx_q <= 3'h0;
		end else begin
			rd_q <= take && !hwrite;
			st_q <= take && !hwrite && haddr[4:2] == 3'h2;
			wr_q <= take && hwrite && hsize == 3'h2;
			idx_q <= haddr[4:2];
			if (wr_q && idx_q == 3'h0)
				en_q <= hwdata[2];
			if (wr_q && idx_q == 3'h6)
				msk_q <= |hwdata[1:0];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	a_open_drain: assert property (!scl_o && !sda_o)
		else $error("bus line driven high");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_rdata_phase: assert property (hrdata != 32'h0 |-> rd_q)
		else $error("read data outside data phase");
	a_stat_layout: assert property (st_q |-> hrdata[31:8] == 24'h0
		&& !hrdata[2]) else $error("status layout wrong");
	a_stretch_scl: assert property (st_q && hrdata[7:3] != 5'h1f
		&& hrdata[7:3] != 5'h07 && hrdata[7:3] != 5'h14 |-> scl_oe)
		else $error("clock line not held while flag set");
	a_idle_lines: assert property (!en_q [*3] |-> !scl_oe && !sda_oe)
		else $error("lines driven while disabled");
	a_irq_mask: assert property (!msk_q [*2] |-> !irq)
		else $error("interrupt while fully masked");
	a_reset_quiet: assert property ($rose(reset_n) |-> !sda_oe)
		else $error("data line driven after reset");
endmodule : twh_top_chk
bind twh_top twh_top_chk twh_top_chk_inst (.clock(clock),
	.reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe));
